//--- hdl/sdp_pkg.sv
// Package of constants and types for the serial delimiter packer
package sdp_pkg;
	// Buffer geometry
	localparam int BUF_DEPTH = 1024;
	localparam int PTR_W     = 11;
	// Timing: 1 ms tick from the 100 MHz clock
	localparam int CLK_MHZ     = 100;
	localparam int TICK_US     = 1000;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_DELIM   = 8'h04;
	localparam logic [7:0] REG_LENGTH  = 8'h08;
	localparam logic [7:0] REG_FLUSH   = 8'h0c;
	localparam logic [7:0] REG_INACT   = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	// Control field positions
	localparam int CTRL_EN1_BIT  = 0;
	localparam int CTRL_EN2_BIT  = 1;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_CONN_BIT = 8;
	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] DELIM_RST = 16'h0000;
	// Delimiter handling modes
	typedef enum logic [1:0] {
		MODE_KEEP,
		MODE_PLUS1,
		MODE_PLUS2,
		MODE_STRIP
	} sdp_mode_t;
endpackage

//--- hdl/sdp_buf_if.sv
// Interface between the packer core and its byte store
`timescale 1ns/1ns
`default_nettype none
interface sdp_buf_if;
	logic                    wr_en;    // Write strobe
	logic [sdp_pkg::PTR_W-2:0] wr_addr; // Write index
	logic [7:0]              wr_data;  // Byte in
	logic [sdp_pkg::PTR_W-2:0] rd_addr; // Read index
	logic [7:0]              rd_data;  // Byte out, registered
	modport core (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- hdl/sdp_buf.sv
// Flip-flop byte store for one packet
`timescale 1ns/1ns
`default_nettype none
module sdp_buf
	import sdp_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Store port
	sdp_buf_if.mem   bus
);
	logic [7:0] mem [BUF_DEPTH];   // Storage array

	// Write port
	always_ff @(posedge clk_i) begin
		if (bus.wr_en) begin
			mem[bus.wr_addr] <= bus.wr_data;
		end
	end

	// Registered read, one cycle latency
	always_ff @(posedge clk_i) begin
		bus.rd_data <= mem[bus.rd_addr];
	end
endmodule
`default_nettype wire

//--- hdl/sdp_packer.sv
// Delimiter packer top: APB registers, gathering and frame output
`timescale 1ns/1ns
`default_nettype none
module sdp_packer
	import sdp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Serial byte input
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	// Packet output
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	output logic             tx_sop_o,
	output logic             tx_eop_o,
	// Connection state
	output logic             conn_open_o,
	// Bytes dropped while a packet drains
	output logic             rx_drop_o
);
	// Configuration registers
	logic [31:0]       ctrl;        // Enables and mode; connection bit is held in conn_open_o
	logic [15:0]       delim;       // [7:0] first, [15:8] second
	logic [10:0]       pkt_len;     // Length limit, 0 disables
	logic [15:0]       flush_ms;    // Forced flush timeout
	logic [15:0]       inact_ms;    // Inactivity close time

	// Packing state
	typedef enum logic [1:0] {
		ST_GATHER,
		ST_TRAIL,
		ST_DRAIN
	} sdp_state_t;
	sdp_state_t        state;       // Main state
	logic [PTR_W-1:0]  count;       // Bytes stored
	logic [PTR_W-1:0]  send_len;    // Bytes to emit
	logic [PTR_W-1:0]  rd_ptr;      // Drain index
	logic [1:0]        trail_left;  // Trailing bytes still wanted
	logic              prev_d1;     // Last byte was first delimiter
	logic [16:0]       tick_cnt;    // Millisecond divider
	logic              tick;        // One-cycle 1 ms pulse
	logic [15:0]       idle_ms;     // Idle gap for flush
	logic [15:0]       inact_cnt;   // Idle gap for close
	logic              rd_valid;    // Read data valid next cycle
	logic              rd_last;     // That read is the last byte
	logic              rd_first;    // That read is the first byte

	// Store carrier; read data lags the index by one cycle
	sdp_buf_if bif();

	// Byte store
	sdp_buf u_buf (
		.clk_i (clk_i),
		.bus   (bif)
	);

	// Decoded configuration
	// Mode is only acted on while delimiter one is enabled
	logic      en1;
	logic      en2;
	sdp_mode_t mode;
	assign en1  = ctrl[CTRL_EN1_BIT];
	assign en2  = ctrl[CTRL_EN2_BIT];
	assign mode = sdp_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);

	// Byte accepted while gathering or waiting for trailer bytes
	// Bytes seen during a drain are flagged as drops, never stored
	logic take;
	assign take = rx_valid_i && (state != ST_DRAIN);

	// Delimiter match on the incoming byte
	logic match;
	always_comb begin
		match = 1'b0;
		if (take && en1) begin
			if (en2) begin
				match = prev_d1 && (rx_data_i == delim[15:8]);
			end else begin
				match = (rx_data_i == delim[7:0]);
			end
		end
	end

	// Store write; strip mode drops the matching byte
	logic store;
	assign store = take && !(match && mode == MODE_STRIP);
	assign bif.wr_en   = store;
	assign bif.wr_addr = count[PTR_W-2:0];
	assign bif.wr_data = rx_data_i;
	assign bif.rd_addr = rd_ptr[PTR_W-2:0];

	// Count after this byte
	// A stripped delimiter leaves the count as it was
	logic [PTR_W-1:0] count_new;
	assign count_new = store ? count + 1'b1 : count;

	// Release decisions for the current cycle
	logic full_hit;
	logic len_hit;
	logic idle_hit;
	logic trail_done;
	assign full_hit   = (count_new == PTR_W'(BUF_DEPTH));
	assign len_hit    = (pkt_len != '0) && (count_new >= pkt_len);
	assign idle_hit   = (flush_ms != '0) && (idle_ms >= flush_ms) &&
	                    (count != '0) && !take;
	assign trail_done = (state == ST_TRAIL) && take && (trail_left == 2'd1);

	// Delimiter release now (keep or strip), or start of trailer wait
	logic delim_now;
	logic delim_wait;
	assign delim_now  = match && (state == ST_GATHER) &&
	                    (mode == MODE_KEEP || mode == MODE_STRIP);
	assign delim_wait = match && (state == ST_GATHER) &&
	                    (mode == MODE_PLUS1 || mode == MODE_PLUS2);

	// Any release source starts a drain; a drain blocks new ones
	logic release_now;
	assign release_now = (state != ST_DRAIN) &&
	    (delim_now || trail_done || full_hit || len_hit || idle_hit);

	// Strip of a two-byte delimiter also removes the stored first byte
	// A single-byte strip simply never stores the delimiter
	logic [PTR_W-1:0] strip_len;
	assign strip_len = (en2 && count != '0) ? count - 1'b1 : count;

	// Main packing state machine
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state      <= ST_GATHER;
			count      <= '0;
			send_len   <= '0;
			trail_left <= 2'd0;
		end else begin
			case (state)
				ST_GATHER, ST_TRAIL: begin
					count <= count_new;
					if (release_now) begin
						state <= ST_DRAIN;
						if (delim_now && mode == MODE_STRIP) begin
							send_len <= strip_len;
						end else begin
							send_len <= count_new;
						end
					end else if (delim_wait) begin
						state      <= ST_TRAIL;
						trail_left <= (mode == MODE_PLUS2) ? 2'd2 : 2'd1;
					end else if (state == ST_TRAIL && take) begin
						// Trailer bytes count whatever their value
						trail_left <= trail_left - 2'd1;
					end
				end
				ST_DRAIN: begin
					// Empty packet after strip: nothing to send
					if (send_len == '0 || rd_ptr == send_len) begin
						state <= ST_GATHER;
						count <= '0;
					end
				end
				default: state <= ST_GATHER;
			endcase
		end
	end

	// Two-byte pattern tracker
	// Only bytes actually taken move the tracker
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prev_d1 <= 1'b0;
		end else if (take) begin
			// Pattern cannot span a packet boundary released on a taken byte; an idle flush leaves it set
			prev_d1 <= (rx_data_i == delim[7:0]) && !release_now;
		end
	end

	// Drain read pointer
	// Limitation: no back-pressure, a frame always runs at full rate
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_ptr   <= '0;
			rd_valid <= 1'b0;
			rd_last  <= 1'b0;
			rd_first <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			rd_last  <= 1'b0;
			rd_first <= 1'b0;
			if (state == ST_DRAIN && rd_ptr != send_len) begin
				rd_ptr   <= rd_ptr + 1'b1;
				rd_valid <= 1'b1;
				rd_first <= (rd_ptr == '0);
				rd_last  <= (rd_ptr == send_len - 1'b1);
			end else if (state != ST_DRAIN) begin
				rd_ptr <= '0;
			end
		end
	end

	// Frame output registers
	// Data reads zero outside frames so the idle bus stays quiet
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
			tx_sop_o   <= 1'b0;
			tx_eop_o   <= 1'b0;
		end else begin
			tx_valid_o <= rd_valid;
			tx_data_o  <= rd_valid ? bif.rd_data : 8'h00;
			tx_sop_o   <= rd_first;
			tx_eop_o   <= rd_last;
		end
	end

	// Bytes arriving during drain are lost; flag them
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_drop_o <= 1'b0;
		end else begin
			rx_drop_o <= rx_valid_i && (state == ST_DRAIN);
		end
	end

	// Millisecond tick divider, restarted by every byte and by a drain
	// so the first tick lands a whole millisecond after the last byte
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (rx_valid_i || state == ST_DRAIN) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick     <= 1'b0;
		end
	end

	// Idle gap for forced flush, restarted by data and release
	// Saturates so a long silence never wraps below the timeout
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			idle_ms <= '0;
		end else if (rx_valid_i || state == ST_DRAIN) begin
			idle_ms <= '0;
		end else if (tick && idle_ms != 16'hffff) begin
			idle_ms <= idle_ms + 1'b1;
		end
	end

	// Inactivity close of the connection
	// A control write from software wins over the close timer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			inact_cnt   <= '0;
			conn_open_o <= 1'b0;
		end else if (psel_i && penable_i && pwrite_i &&
		             paddr_i == REG_CTRL) begin
			// Software opens or closes the link directly
			conn_open_o <= pwdata_i[CTRL_CONN_BIT];
			inact_cnt   <= '0;
		end else if (rx_valid_i || tx_valid_o) begin
			inact_cnt <= '0;
		end else if (tick && conn_open_o && inact_ms != '0) begin
			if (inact_cnt + 1'b1 >= inact_ms) begin
				conn_open_o <= 1'b0;
				inact_cnt   <= '0;
			end else begin
				inact_cnt <= inact_cnt + 1'b1;
			end
		end
	end

	// APB register writes, taken in the access phase
	// Length bits [10:0] above the store size clamp to a full store; higher bits are ignored
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl     <= CTRL_RST;
			delim    <= DELIM_RST;
			pkt_len  <= '0;
			flush_ms <= '0;
			inact_ms <= '0;
		end else if (psel_i && penable_i && pwrite_i) begin
			case (paddr_i)
				REG_CTRL:   ctrl     <= pwdata_i & 32'h0000_0033;
				REG_DELIM:  delim    <= pwdata_i[15:0];
				REG_LENGTH: pkt_len  <= (pwdata_i[10:0] > 11'd1024) ?
				                        11'd1024 : pwdata_i[10:0];
				REG_FLUSH:  flush_ms <= pwdata_i[15:0];
				REG_INACT:  inact_ms <= pwdata_i[15:0];
				default:    ;
			endcase
		end
	end

	// Known register offset
	// Unmapped offsets answer with an error and read as zero
	function automatic logic known(input logic [7:0] a);
		known = (a == REG_CTRL) || (a == REG_DELIM) || (a == REG_LENGTH) ||
		        (a == REG_FLUSH) || (a == REG_INACT) || (a == REG_STATUS);
	endfunction

	// APB read data, ready and error; zero wait states
	// Status packs state and count for software polling
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			// Ready rises in the access cycle, after one setup cycle
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !known(paddr_i);
			prdata_o  <= '0;
			if (psel_i && !penable_i && !pwrite_i) begin
				case (paddr_i)
					REG_CTRL:   prdata_o <= ctrl | {23'h0, conn_open_o, 8'h00};
					REG_DELIM:  prdata_o <= {16'h0000, delim};
					REG_LENGTH: prdata_o <= {21'h0, pkt_len};
					REG_FLUSH:  prdata_o <= {16'h0000, flush_ms};
					REG_INACT:  prdata_o <= {16'h0000, inact_ms};
					REG_STATUS: prdata_o <= {14'h0, state, 5'h0, count};
					default:    prdata_o <= '0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/sdp_src.sv
// Byte source standing in for the attached serial device
`timescale 1ns/1ns
`default_nettype none
module sdp_src (
	// Clock
	input  wire logic  clk_i,
	// Byte stream
	output logic       rx_valid_o,
	output logic [7:0] rx_data_o
);
	// Quiet line at time zero
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
	end
	// One byte, then the inverse so stale data never looks valid
	task send(input logic [7:0] b, input int gap);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o  <= b;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o  <= ~b;
		repeat (gap) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- sim/sdp_packer_chk.sv
// Port assertions for the delimiter packer
`timescale 1ns/1ns
`default_nettype none
module sdp_packer_chk (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       reset_i,
	// APB
	input wire logic       psel_i,
	input wire logic       penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic       pready_o,
	input wire logic       pslverr_o,
	// Byte streams
	input wire logic       rx_valid_i,
	input wire logic       tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       tx_sop_o,
	input wire logic       tx_eop_o,
	input wire logic       rx_drop_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_rdy_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready not one cycle after setup");
	a_rdy_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("pready held too long");
	a_err_unmapped: assert property (pready_o && paddr_i[1:0] == 2'h0
		|-> pslverr_o == (paddr_i > 8'h14))
		else $error("pslverr wrong for address");
	a_sop_first: assert property ($rose(tx_valid_o) |-> tx_sop_o)
		else $error("frame without start mark");
	a_frame_run: assert property (tx_valid_o && !tx_eop_o
		|=> tx_valid_o && !tx_sop_o)
		else $error("frame broken up");
	a_marks_valid: assert property (tx_sop_o || tx_eop_o |-> tx_valid_o)
		else $error("mark without byte");
	a_idle_zero: assert property (!tx_valid_o |-> tx_data_o == 8'h00)
		else $error("data not zero when idle");
	a_drop_cause: assert property (rx_drop_o |-> $past(rx_valid_i))
		else $error("drop without byte");
	// Main scenarios
	c_short: cover property (tx_sop_o && tx_eop_o);
	c_drop: cover property (rx_drop_o);
	c_err: cover property (pready_o && pslverr_o);
endmodule
bind sdp_packer sdp_packer_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_sop_o(tx_sop_o),
	.tx_eop_o(tx_eop_o), .rx_drop_o(rx_drop_o));
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the delimiter packer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import sdp_pkg::*;
	logic        clk_i = 1'b0;   // Clock
	logic        reset_i = 1'b1; // Reset
	logic        psel_i = 1'b0;  // APB request
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, r;    // Read data, last read
	logic        pready_o, pslverr_o, er;
	logic        rx_valid_i, tx_valid_o, tx_sop_o, tx_eop_o;
	logic [7:0]  rx_data_i, tx_data_o, d;
	logic        conn_open_o, rx_drop_o;
	logic [7:0]  got[$], exq[$]; // Bytes seen, bytes expected
	logic [1:0]  m;              // Handling mode
	int          err_total = 0, n_tests = 0, frames = 0, drops = 0;
	int          cyc = 0, el;
	always #5 clk_i = ~clk_i;
	sdp_packer i_sdp_packer (.clk_i(clk_i), .reset_i(reset_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_sop_o(tx_sop_o), .tx_eop_o(tx_eop_o),
		.conn_open_o(conn_open_o), .rx_drop_o(rx_drop_o));
	sdp_src i_sdp_src (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i));
	task final_report;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Gather output bytes; the cycle ceiling stops a hang
	always @(posedge clk_i) begin
		cyc++;
		if (tx_valid_o === 1'b1) got.push_back(tx_data_o);
		if (tx_eop_o === 1'b1) frames++;
		if (rx_drop_o === 1'b1) drops++;
		if (cyc == 200000) begin
			err_total++;
			final_report();
		end
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task apb(input bit w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= v;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// Send a byte at a random pace; k says it lands in the packet
	task put(input logic [7:0] b, input bit k);
		i_sdp_src.send(b, $urandom % 3);
		if (k) exq.push_back(b);
	endtask
	// Wait for one frame and compare it byte by byte
	task pkt(input int lim);
		el = 0;
		while (frames == 0 && el < lim) begin
			@(posedge clk_i);
			el++;
		end
		chk("frames", 1, frames);
		chk("length", exq.size(), got.size());
		foreach (exq[i]) chk("byte", exq[i], got[i]);
		frames = 0;
		got = {};
		exq = {};
	endtask
	// Trailing bytes that each handling mode waits for
	function automatic int trail_n(input logic [1:0] md);
		return (md == MODE_PLUS1) ? 1 : (md == MODE_PLUS2) ? 2 : 0;
	endfunction
	initial begin
		r = $urandom(89826);
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", CTRL_RST, r);
		apb(1'b0, REG_DELIM, 32'h0);
		chk("delim", DELIM_RST, r);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h0, r);
		chk("slverr", 1'b1, er);
		apb(1'b1, REG_CTRL, 32'h100);
		// The write lands at the access edge; look one edge later
		@(posedge clk_i);
		chk("conn", 1'b1, conn_open_o);
		// Every handling mode, one and two delimiters
		for (int c = 0; c < 8; c++) begin
			m = c[1:0];
			d = $urandom;
			apb(1'b1, REG_DELIM, {16'h0, d ^ 8'h01, d});
			apb(1'b1, REG_CTRL, {26'h0, m, 2'h0, c[2], 1'b1});
			repeat (1 + $urandom % 4) put(d ^ (8'h02 + $urandom % 254), 1);
			if (c[2]) put(d, 1);
			if (c[2]) put(d ^ 8'h03, 1);
			put(d, m != MODE_STRIP);
			if (c[2]) put(d ^ 8'h01, m != MODE_STRIP);
			repeat (trail_n(m)) put($urandom, 1);
			pkt(2000);
		end
		// Delimiter off: strip ignored, length limit of four
		apb(1'b1, REG_CTRL, 32'h30);
		apb(1'b1, REG_LENGTH, 32'h4);
		apb(1'b0, REG_LENGTH, 32'h0);
		chk("len reg", 32'h4, r);
		put(d, 1);
		repeat (3) put($urandom, 1);
		i_sdp_src.send(8'h55, 0);
		pkt(2000);
		chk("drops", 1, drops);
		// No limit: a full store releases
		apb(1'b1, REG_LENGTH, 32'h0);
		repeat (BUF_DEPTH) put($urandom, 1);
		pkt(5000);
		// Idle release: none at zero, one tick after the last byte;
		// the link stays open since its close time is the longer one
		apb(1'b1, REG_CTRL, 32'h130);
		apb(1'b1, REG_INACT, 32'h2);
		put(8'h3c, 1);
		repeat (2000) @(posedge clk_i);
		chk("no flush", 0, frames);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h1, r);
		apb(1'b1, REG_FLUSH, 32'h1);
		put(8'hc3, 1);
		pkt(120000);
		chk("idle", 1, el > TICK_CYCLES - 100 && el < TICK_CYCLES + 100);
		chk("open", 1, conn_open_o);
		final_report();
	end
endmodule
`default_nettype wire
